// ---- design/flash_cmd_pkg.sv ----
// Package for the flash command framing block: opcodes, address layout,
// dummy-byte counts and power-up timing constants.
// Assumes a 20 MHz system clock; the link clock is a separate domain.
package flash_cmd_pkg;

   // System clock period in picoseconds and power-up figures.
   localparam int unsigned SYS_CLK_PS              = 50000;
   localparam int unsigned SUPPLY_TO_SELECT_US     = 50;   // Least time.
   localparam int unsigned POWERUP_WRITE_DELAY_MS  = 20;   // Longest time.
   localparam int unsigned SUPPLY_TO_SELECT_CYC    =
      (SUPPLY_TO_SELECT_US * 1000000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
   localparam longint unsigned POWERUP_WRITE_CYC   =
      (64'(POWERUP_WRITE_DELAY_MS) * 64'd1000000000) / 64'(SYS_CLK_PS);

   // Address field layout, 1056-byte page configuration.
   localparam int unsigned ADDR_BITS     = 24;
   localparam int unsigned PAGE_BITS     = 13;
   localparam int unsigned OFFSET_BITS   = 11;
   localparam int unsigned PAGE_LSB      = 11;
   localparam int unsigned OFFSET_LSB    = 0;

   // Dummy byte counts after the address, or after the opcode for the status read.
   localparam logic [4:0] DUMMY_PAGE_SER  = 5'h04;
   localparam logic [4:0] DUMMY_PAGE_PAR  = 5'h13;
   localparam logic [4:0] DUMMY_FAST      = 5'h01;
   localparam logic [4:0] DUMMY_STAT_PAR  = 5'h02;

   // Opcodes handled by this block.
   localparam logic [7:0] OP_81 = 8'h81;
   localparam logic [7:0] OP_82 = 8'h82;
   localparam logic [7:0] OP_83 = 8'h83;
   localparam logic [7:0] OP_84 = 8'h84;
   localparam logic [7:0] OP_85 = 8'h85;
   localparam logic [7:0] OP_86 = 8'h86;
   localparam logic [7:0] OP_87 = 8'h87;
   localparam logic [7:0] OP_88 = 8'h88;
   localparam logic [7:0] OP_89 = 8'h89;
   localparam logic [7:0] OP_9F = 8'h9f;
   localparam logic [7:0] OP_B9 = 8'hb9;
   localparam logic [7:0] OP_AB = 8'hab;
   localparam logic [7:0] OP_D1 = 8'hd1;
   localparam logic [7:0] OP_D2 = 8'hd2;
   localparam logic [7:0] OP_D3 = 8'hd3;
   localparam logic [7:0] OP_D4 = 8'hd4;
   localparam logic [7:0] OP_D6 = 8'hd6;
   localparam logic [7:0] OP_D7 = 8'hd7;
   localparam logic [7:0] OP_E8 = 8'he8;

   // How an opcode uses the address field.
   typedef enum logic [2:0] {
      AU_NONE,
      AU_PAGE,
      AU_OFFSET,
      AU_BOTH,
      AU_NOADDR,
      AU_UNKNOWN
   } addr_use_t;

   // Decoded command handed from the link domain to the system domain.
   typedef struct packed {
      logic [7:0]             opcode;
      logic [PAGE_BITS-1:0]   page;
      logic [OFFSET_BITS-1:0] offset;
      logic                   is_write;
      logic                   parallel;
   } cmd_word_t;

   // Decoded opcode properties.
   typedef struct packed {
      addr_use_t  use_t_f;
      logic [4:0] dummy;
      logic       is_write;
   } op_info_t;

   // Opcode property lookup; used by the link receiver on every opcode.
   function automatic op_info_t op_info(input logic [7:0] op, input logic par);
      op_info_t r;
      r = '{use_t_f: AU_UNKNOWN, dummy: 5'h00, is_write: 1'b0};
      unique case (op)
         OP_84, OP_87: r = '{use_t_f: AU_OFFSET, dummy: 5'h00, is_write: 1'b0};
         OP_D1, OP_D3: r = '{use_t_f: AU_OFFSET, dummy: 5'h00, is_write: 1'b0};
         OP_D4, OP_D6: r = '{use_t_f: AU_OFFSET, dummy: DUMMY_FAST, is_write: 1'b0};
         OP_81, OP_83, OP_86, OP_88, OP_89:
            r = '{use_t_f: AU_PAGE, dummy: 5'h00, is_write: 1'b1};
         OP_82, OP_85: r = '{use_t_f: AU_BOTH, dummy: 5'h00, is_write: 1'b1};
         OP_D2, OP_E8:
            r = '{use_t_f: AU_BOTH, dummy: par ? DUMMY_PAGE_PAR : DUMMY_PAGE_SER,
                  is_write: 1'b0};
         OP_9F, OP_B9, OP_AB:
            r = '{use_t_f: AU_NOADDR, dummy: 5'h00, is_write: 1'b0};
         OP_D7:
            r = '{use_t_f: AU_NOADDR, dummy: par ? DUMMY_STAT_PAR : 5'h00,
                  is_write: 1'b0};
         default: r = '{use_t_f: AU_UNKNOWN, dummy: 5'h00, is_write: 1'b0};
      endcase
      return r;
   endfunction

endpackage

// ---- design/flash_link_rx.sv ----
// Link-side command receiver: shifts opcode, address and dummy bytes in on
// the link clock and hands out a finished command by toggle.
// Assumes the link clock only runs while chip select is low.
`timescale 1ns/1ps
module flash_link_rx
   import flash_cmd_pkg::*;
(
   input  wire logic       i_clk_link,   // Serial or byte-wide clock.
   input  wire logic       i_sel_n,      // Chip select, active low.
   input  wire logic       i_par_mode,   // Byte-wide link selected.
   input  wire logic       i_serial_in,  // Serial data in.
   input  wire logic [7:0] i_par_in,     // Byte-wide data lines in.
   input  wire logic       i_enable,     // Synchronised: commands accepted.
   output logic            o_toggle,     // Flips once per completed command.
   output cmd_word_t       o_cmd         // Opcode loads at each frame start; the rest loads with the last address byte (or the opcode), ahead of any dummy bytes.
);

   typedef enum logic [1:0] {ST_OP, ST_ADDR, ST_DUMMY, ST_DONE} rx_state_t;

   typedef struct packed {
      rx_state_t  state;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [4:0] dummy_cnt;
      logic [7:0] shreg;
      logic [ADDR_BITS-1:0] addr;
      op_info_t   info;
   } rx_regs_t;

   // Toggle and command outlive the frame, so they sit apart from the
   // framing state that chip select clears.
   typedef struct packed {
      logic       toggle;
      cmd_word_t  cmd;
   } rx_hold_t;

   rx_regs_t cur_ff;
   rx_regs_t nxt_cur;
   rx_hold_t hold_ff;
   rx_hold_t nxt_hold;
   logic [7:0] byte_in;
   logic       byte_done;

   // Chip select high clears framing asynchronously: a frame always starts on
   // its falling edge, because this clock may stop between frames.
   always_comb begin
      nxt_cur   = cur_ff;
      nxt_hold  = hold_ff;
      byte_in   = i_par_mode ? i_par_in : {cur_ff.shreg[6:0], i_serial_in};
      byte_done = i_par_mode || (cur_ff.bit_cnt == 3'h7);
      nxt_cur.shreg   = byte_in;
      nxt_cur.bit_cnt = byte_done ? 3'h0 : 3'(cur_ff.bit_cnt + 3'h1);
      // Power reset parks the toggle at a known level; the system side is
      // still in reset then and swallows the step.
      if (!i_enable) begin
         nxt_hold.toggle = 1'b0;
      end
      // A clock edge while deselected must not touch the kept command.
      if (byte_done && !i_sel_n) begin
         unique case (cur_ff.state)
            ST_OP: begin
               nxt_cur.info       = op_info(byte_in, i_par_mode);
               nxt_hold.cmd.opcode = byte_in;
               nxt_cur.byte_cnt   = 2'h0;
               if (!i_enable || nxt_cur.info.use_t_f == AU_UNKNOWN) begin
                  nxt_cur.state = ST_DONE;         // Ignored while in reset.
               end else if (nxt_cur.info.use_t_f == AU_NOADDR) begin
                  // No address for these; the byte-wide status read still
                  // has don't-care bytes before it is announced.
                  nxt_hold.cmd.page     = '0;
                  nxt_hold.cmd.offset   = '0;
                  nxt_hold.cmd.is_write = 1'b0;
                  nxt_hold.cmd.parallel = i_par_mode;
                  nxt_cur.dummy_cnt     = nxt_cur.info.dummy;
                  if (nxt_cur.info.dummy == 5'h00) begin
                     nxt_cur.state   = ST_DONE;
                     nxt_hold.toggle = ~hold_ff.toggle;
                  end else begin
                     nxt_cur.state = ST_DUMMY;
                  end
               end else begin
                  nxt_cur.state = ST_ADDR;
               end
            end
            ST_ADDR: begin
               nxt_cur.addr     = {cur_ff.addr[ADDR_BITS-9:0], byte_in}; // MSB first.
               nxt_cur.byte_cnt = 2'(cur_ff.byte_cnt + 2'h1);
               if (cur_ff.byte_cnt == 2'h2) begin
                  // Split page and offset, zeroing unused positions.
                  nxt_hold.cmd.page = (cur_ff.info.use_t_f inside {AU_PAGE, AU_BOTH}) ?
                     nxt_cur.addr[PAGE_LSB +: PAGE_BITS] : '0;
                  nxt_hold.cmd.offset = (cur_ff.info.use_t_f inside {AU_OFFSET, AU_BOTH}) ?
                     nxt_cur.addr[OFFSET_LSB +: OFFSET_BITS] : '0;
                  nxt_hold.cmd.is_write = cur_ff.info.is_write;
                  nxt_hold.cmd.parallel = i_par_mode;
                  nxt_cur.dummy_cnt     = cur_ff.info.dummy;
                  if (cur_ff.info.dummy == 5'h00) begin
                     nxt_cur.state   = ST_DONE;
                     nxt_hold.toggle = ~hold_ff.toggle;
                  end else begin
                     nxt_cur.state = ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               // Host clocks don't-care bytes; the command is announced after them.
               nxt_cur.dummy_cnt = 5'(cur_ff.dummy_cnt - 5'h01);
               if (cur_ff.dummy_cnt == 5'h01) begin
                  nxt_cur.state   = ST_DONE;
                  nxt_hold.toggle = ~hold_ff.toggle;
               end
            end
            ST_DONE: nxt_cur.state = ST_DONE;  // Data phase is beyond this block.
         endcase
      end
   end

   // Framing resets on chip select high; toggle and command are kept.
   always_ff @(posedge i_clk_link or posedge i_sel_n) begin
      if (i_sel_n) begin
         cur_ff.state     <= ST_OP;            // Start only after CS falls.
         cur_ff.bit_cnt   <= 3'h0;
         cur_ff.byte_cnt  <= 2'h0;
         cur_ff.dummy_cnt <= 5'h00;
         cur_ff.shreg     <= 8'h00;
         cur_ff.addr      <= '0;
         cur_ff.info      <= '{use_t_f: AU_NONE, dummy: 5'h00, is_write: 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Kept state has no reset of its own: chip select must not wipe a command
   // that the system side may still be sampling.
   always_ff @(posedge i_clk_link) begin
      hold_ff <= nxt_hold;
   end

   assign o_toggle = hold_ff.toggle;
   assign o_cmd    = hold_ff.cmd;

endmodule

// ---- design/flash_cmd_addressing.sv ----
// Top of the flash command framing block: power-on state, clock mode
// detection and the system-side view of decoded commands.
// Assumes i_clk_sys at 20 MHz and a link clock from the host, stopped outside frames.
`timescale 1ns/1ps
module flash_cmd_addressing
   import flash_cmd_pkg::*;
#(
   parameter longint unsigned WRITE_DELAY_CYC = POWERUP_WRITE_CYC
)
(
   input  wire logic        i_clk_sys,        // System clock, 20 MHz.
   input  wire logic        i_rst_n,          // Synchronous reset, active low.
   input  wire logic        i_por_n,          // Supply above por_threshold.
   input  wire logic        i_clk_link,       // Host link clock.
   input  wire logic        i_sel_n,          // Chip select, active low.
   input  wire logic        i_par_mode,       // High selects the byte-wide link.
   input  wire logic        i_serial_in,      // Serial data in.
   input  wire logic [7:0]  i_par_in,         // parallel_data_lines inputs.
   input  wire logic        i_busy,           // Adaptive array engine busy.
   output logic             o_serial_out,     // Serial data out.
   output logic             o_serial_oe,      // Serial out enable.
   output logic [7:0]       o_par_out,        // parallel_data_lines outputs.
   output logic             o_par_oe,         // parallel_data_lines enable.
   output logic             o_mode3,          // Clock mode 3 when high, else 0.
   output logic             o_standby,        // Device idle in standby.
   output logic             o_ready,          // Ready level for status polling.
   output logic             o_cmd_valid,      // One-cycle pulse: command decoded.
   output cmd_word_t        o_cmd,            // Decoded command.
   output logic             o_write_allowed   // Write delay has passed.
);

   typedef enum logic [1:0] {PW_RESET, PW_STANDBY, PW_ACTIVE} pwr_state_t;

   typedef struct packed {
      logic [1:0] por_sync;
      logic [1:0] sel_sync;
      logic [1:0] clk_sync;
      logic [1:0] tog_sync;
      logic       sel_last;
      logic       tog_last;
      logic       mode3;
      pwr_state_t pstate;
      logic [31:0] wr_cnt;
      logic       write_ok;
      logic       cmd_valid;
      cmd_word_t  cmd;
      logic       ready;
      logic       standby;
   } top_regs_t;

   top_regs_t cur_ff;
   top_regs_t nxt_cur;
   logic      link_toggle;
   cmd_word_t link_cmd;
   logic [1:0] en_sync_ff;

   // Commands are refused while power-on reset holds; this level crosses
   // into the link domain through two flip-flops.
   always_ff @(posedge i_clk_link) begin
      en_sync_ff <= {en_sync_ff[0], cur_ff.pstate != PW_RESET};
   end

   // Link-domain receiver for both serial and byte-wide framing.
   flash_link_rx u_rx (
      .i_clk_link  (i_clk_link),
      .i_sel_n     (i_sel_n),
      .i_par_mode  (i_par_mode),
      .i_serial_in (i_serial_in),
      .i_par_in    (i_par_in),
      .i_enable    (en_sync_ff[1]),
      .o_toggle    (link_toggle),
      .o_cmd       (link_cmd)
   );

   // Next-state logic. The command word is sampled only once the toggle
   // has crossed, so it has been stable for at least two system cycles.
   always_comb begin
      nxt_cur          = cur_ff;
      nxt_cur.por_sync = {cur_ff.por_sync[0], i_por_n};
      nxt_cur.sel_sync = {cur_ff.sel_sync[0], i_sel_n};
      nxt_cur.clk_sync = {cur_ff.clk_sync[0], i_clk_link};
      nxt_cur.tog_sync = {cur_ff.tog_sync[0], link_toggle};
      nxt_cur.sel_last = cur_ff.sel_sync[1];
      nxt_cur.tog_last = cur_ff.tog_sync[1];
      nxt_cur.cmd_valid = 1'b0;
      nxt_cur.ready     = !i_busy;       // Completion is seen by polling.

      // Idle clock level at the select fall picks the mode.
      if (cur_ff.sel_last && !cur_ff.sel_sync[1]) begin
         nxt_cur.mode3 = cur_ff.clk_sync[1];
      end

      unique case (cur_ff.pstate)
         PW_RESET: begin
            nxt_cur.wr_cnt = 32'h0;
            if (cur_ff.por_sync[1]) begin
               nxt_cur.pstate = PW_STANDBY;      // Power-up ends in standby.
            end
         end
         PW_STANDBY: begin
            if (!cur_ff.sel_sync[1]) begin
               nxt_cur.pstate = PW_ACTIVE;
            end
         end
         PW_ACTIVE: begin
            if (cur_ff.sel_sync[1] && !i_busy) begin
               nxt_cur.pstate = PW_STANDBY;
            end
         end
         default: nxt_cur.pstate = PW_RESET;
      endcase

      // Write delay counter; host must respect it, the flag reports it.
      if (cur_ff.pstate != PW_RESET && !cur_ff.write_ok) begin
         nxt_cur.wr_cnt = 32'(cur_ff.wr_cnt + 32'h1);
         if (64'(cur_ff.wr_cnt) + 64'd1 >= WRITE_DELAY_CYC) begin
            nxt_cur.write_ok = 1'b1;
         end
      end

      if (cur_ff.tog_sync[1] != cur_ff.tog_last && cur_ff.pstate != PW_RESET) begin
         nxt_cur.cmd_valid = 1'b1;
         nxt_cur.cmd       = link_cmd;
      end

      // Supply loss drops straight back to reset; a command crossing in that same cycle is still announced.
      if (!cur_ff.por_sync[1]) begin
         nxt_cur.pstate   = PW_RESET;
         nxt_cur.write_ok = 1'b0;
         nxt_cur.mode3    = 1'b1;
      end

      // Registered so the standby output comes straight from a flip-flop.
      nxt_cur.standby = (nxt_cur.pstate == PW_STANDBY);
   end

   // State register with synchronous reset.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         cur_ff.por_sync  <= 2'h0;
         cur_ff.sel_sync  <= 2'h3;
         cur_ff.clk_sync  <= 2'h3;
         cur_ff.tog_sync  <= 2'h0;
         cur_ff.sel_last  <= 1'b1;
         cur_ff.tog_last  <= 1'b0;
         cur_ff.mode3     <= 1'b1;                // Mode 3 after reset.
         cur_ff.pstate    <= PW_RESET;
         cur_ff.wr_cnt    <= 32'h0;
         cur_ff.write_ok  <= 1'b0;
         cur_ff.cmd_valid <= 1'b0;
         cur_ff.cmd       <= '0;
         cur_ff.ready     <= 1'b0;
         cur_ff.standby   <= 1'b0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Data phase is not part of this block, so outputs stay released.
   assign o_serial_out    = 1'b0;
   assign o_serial_oe     = 1'b0;
   assign o_par_out       = 8'h00;
   assign o_par_oe        = 1'b0;
   assign o_mode3         = cur_ff.mode3;
   assign o_standby       = cur_ff.standby;
   assign o_ready         = cur_ff.ready;
   assign o_cmd_valid     = cur_ff.cmd_valid;
   assign o_cmd           = cur_ff.cmd;
   assign o_write_allowed = cur_ff.write_ok;

endmodule

// ---- verification/flash_cmd_addressing_sva.sv ----
// Checker for the command framing top: output release, clock mode, decode fields,
// power-up gating and status levels. Sees only the top ports; bound below.
`timescale 1ns/1ps
module flash_cmd_addressing_sva
   import flash_cmd_pkg::*;
#(
   parameter longint unsigned WRITE_DELAY_CYC = POWERUP_WRITE_CYC
)
(
   input wire logic      i_clk_sys,       // System clock.
   input wire logic      i_rst_n,         // Reset, active low.
   input wire logic      i_por_n,         // Supply good.
   input wire logic      i_clk_link,      // Link clock.
   input wire logic      i_sel_n,         // Chip select, active low.
   input wire logic      i_busy,          // Engine busy.
   input wire logic      o_serial_oe,     // Serial enable.
   input wire logic      o_par_oe,        // Byte lane enable.
   input wire logic      o_mode3,         // Clock mode.
   input wire logic      o_standby,       // Standby.
   input wire logic      o_ready,         // Ready level.
   input wire logic      o_cmd_valid,     // Command pulse.
   input wire cmd_word_t o_cmd,           // Decoded command.
   input wire logic      o_write_allowed  // Write gate.
);
   logic [31:0] up_cnt_ff;
   logic [7:0]  op;

   // Cycles since the supply came good; it saturates so that it never wraps.
   always_ff @(posedge i_clk_sys) begin
      if (!i_por_n)
         up_cnt_ff <= 32'h0;
      else if (up_cnt_ff != 32'hffffffff)
         up_cnt_ff <= up_cnt_ff + 32'h1;
   end
   assign op = o_cmd.opcode;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   property p_hiz; o_serial_oe == 1'b0 && o_par_oe == 1'b0; endproperty
   a_hiz: assert property (p_hiz) else $error("output enable raised");
   property p_rst_mode3; $rose(i_rst_n) |-> o_mode3; endproperty
   a_rst_mode3: assert property (p_rst_mode3) else $error("mode not 3 at reset");
   // The idle clock is held for six cycles after the select edge, so five is safe.
   property p_mode; $fell(i_sel_n) && i_por_n |-> ##5 (o_mode3 == $past(i_clk_link, 5)); endproperty
   a_mode: assert property (p_mode) else $error("mode not idle level");
   property p_pulse; o_cmd_valid |=> !o_cmd_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
   property p_hold; !$stable(o_cmd) |-> o_cmd_valid; endproperty
   a_hold: assert property (p_hold) else $error("command changed without valid");
   property p_offs; o_cmd_valid && op inside {8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6}
      |-> o_cmd.page == 13'h0; endproperty
   a_offs: assert property (p_offs) else $error("page kept on offset opcode");
   property p_page; o_cmd_valid && op inside {8'h81, 8'h83, 8'h86, 8'h88, 8'h89}
      |-> o_cmd.offset == 11'h0; endproperty
   a_page: assert property (p_page) else $error("offset kept on page opcode");
   property p_none; o_cmd_valid && op inside {8'h9f, 8'hb9, 8'hab, 8'hd7}
      |-> o_cmd.page == 13'h0 && o_cmd.offset == 11'h0; endproperty
   a_none: assert property (p_none) else $error("address kept on plain opcode");
   property p_por; (!i_por_n) [*3] |-> !o_cmd_valid && !o_write_allowed; endproperty
   a_por: assert property (p_por) else $error("activity in power reset");
   property p_wr_lo; o_write_allowed |-> up_cnt_ff >= WRITE_DELAY_CYC; endproperty
   a_wr_lo: assert property (p_wr_lo) else $error("write gate early");
   property p_wr_hi; up_cnt_ff == WRITE_DELAY_CYC + 8 |-> o_write_allowed; endproperty
   a_wr_hi: assert property (p_wr_hi) else $error("write gate late");
   property p_ready; $past(i_rst_n) && $past(i_por_n, 6) |-> o_ready == !$past(i_busy); endproperty
   a_ready: assert property (p_ready) else $error("ready not busy inverse");
   property p_stby; (i_sel_n && !i_busy && i_por_n) [*8] |-> o_standby; endproperty
   a_stby: assert property (p_stby) else $error("not in standby when idle");

   c_par: cover property (o_cmd_valid && o_cmd.parallel);
   c_wr: cover property (o_cmd_valid && o_cmd.is_write);
   c_mode0: cover property ($fell(o_mode3));
endmodule

bind flash_cmd_addressing flash_cmd_addressing_sva #(.WRITE_DELAY_CYC(WRITE_DELAY_CYC)) i_sva (
   .i_clk_sys, .i_rst_n, .i_por_n, .i_clk_link, .i_sel_n, .i_busy, .o_serial_oe, .o_par_oe,
   .o_mode3, .o_standby, .o_ready, .o_cmd_valid, .o_cmd, .o_write_allowed);

// ---- verification/host_link_model.sv ----
// Host model that frames commands on the serial or byte-wide link.
// Assumes the bench calls frame, waits for the answer, then calls close.
`timescale 1ns/1ps
module host_link_model (
   output logic       o_sel_n,     // Chip select, active low.
   output logic       o_clk,       // Link clock, still outside frames.
   output logic       o_par_mode,  // Byte-wide link chosen.
   output logic       o_ser,       // Serial data to the device.
   output logic [7:0] o_par        // parallel_data_lines from the host.
);
   initial begin
      o_sel_n = 1'b1;
      o_clk = 1'b1;
      o_par_mode = 1'b0;
      o_ser = 1'b0;
      o_par = 8'h00;
   end

   // Parks the clock at its idle level, selects, then sends each unit on a rising edge.
   task automatic frame(input logic par, input logic idle_hi, input logic [7:0] b[$]);
      int n;
      n = par ? b.size() : b.size() * 8;
      o_par_mode = par;
      o_clk = idle_hi;
      #20 o_sel_n = 1'b0;
      #300;                // Idle level must stand while the select edge is sampled.
      for (int i = 0; i < n; i++) begin
         o_clk = 1'b0;
         if (par)
            o_par = b[i];
         else
            o_ser = b[i / 8][7 - i % 8];  // Opcode then address, MSB first.
         #32 o_clk = 1'b1;
         #32;
      end
      o_clk = idle_hi;
      // Lines no longer carry data, so they must not show the last value.
      o_ser = ~o_ser;
      o_par = ~o_par;
   endtask

   task automatic close();
      #20 o_sel_n = 1'b1;
   endtask
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the command framing top with a host link model.
// Assumes the checker is bound by its own file; write delay shortened to 16 cycles.
`timescale 1ns/1ps
module tb_top;
   import flash_cmd_pkg::*;
   logic       i_clk_sys = 1'b0;
   logic       i_rst_n = 1'b0;
   logic       i_por_n = 1'b0;
   logic       i_busy = 1'b0;
   logic       sel_n, clk_link, par_mode, ser;
   logic [7:0] par;
   logic       o_serial_oe, o_par_oe, o_mode3, o_standby, o_ready, o_cmd_valid;
   logic       o_write_allowed;
   cmd_word_t  o_cmd;
   int         n_fail = 0;
   int         n_checks = 0;

   always #25 i_clk_sys = ~i_clk_sys;

   host_link_model i_host (.o_sel_n(sel_n), .o_clk(clk_link), .o_par_mode(par_mode),
      .o_ser(ser), .o_par(par));
   flash_cmd_addressing #(.WRITE_DELAY_CYC(16)) i_dut (.i_clk_sys, .i_rst_n, .i_por_n,
      .i_clk_link(clk_link), .i_sel_n(sel_n), .i_par_mode(par_mode), .i_serial_in(ser),
      .i_par_in(par), .i_busy, .o_serial_out(), .o_serial_oe, .o_par_out(), .o_par_oe,
      .o_mode3, .o_standby, .o_ready, .o_cmd_valid, .o_cmd, .o_write_allowed);

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Inputs move one nanosecond after the edge so the sample never races.
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One framed command; cfg holds page use, offset use, dummy count and write flag.
   task automatic send(input logic pm, input logic idle_hi, input logic [7:0] op,
                       input logic [23:0] addr, input logic known);
      logic [7:0] q[$];
      logic [7:0] cfg;
      logic       seen;
      seen = 1'b0;
      case (op)
         8'h84, 8'h87, 8'hd1, 8'hd3: cfg = {2'b01, 5'h00, 1'b0};
         8'hd4, 8'hd6: cfg = {2'b01, 5'h01, 1'b0};
         8'h81, 8'h83, 8'h86, 8'h88, 8'h89: cfg = {2'b10, 5'h00, 1'b1};
         8'h82, 8'h85: cfg = {2'b11, 5'h00, 1'b1};
         8'hd2, 8'he8: cfg = {2'b11, pm ? 5'h13 : 5'h04, 1'b0};
         8'hd7: cfg = {2'b00, pm ? 5'h02 : 5'h00, 1'b0};
         default: cfg = 8'h00;
      endcase
      q.push_back(op);
      if (cfg[7:6] != 2'b00)
         q = {q, addr[23:16], addr[15:8], addr[7:0]};
      repeat (cfg[5:1]) q.push_back(8'h5a);
      i_host.frame(pm, idle_hi, q);
      for (int i = 0; i < 12 && !seen; i++) begin
         cyc(1);
         seen = (o_cmd_valid === 1'b1);
      end
      chk("valid", known, seen);
      if (known && seen) begin
         chk("opcode", op, o_cmd.opcode);
         chk("page", cfg[7] ? addr[23:11] : 13'h0, o_cmd.page);
         chk("offset", cfg[6] ? addr[10:0] : 11'h0, o_cmd.offset);
         chk("write", cfg[0], o_cmd.is_write);
         chk("link", pm, o_cmd.parallel);
      end
      if (i_por_n === 1'b1)
         chk("mode", idle_hi, o_mode3);
      i_host.close();
      cyc(4);
   endtask

   task automatic t_power();
      cyc(16);
      i_rst_n = 1'b1;
      cyc(2);
      chk("mode after reset", 1, o_mode3);
      chk("serial enable", 0, o_serial_oe);
      chk("byte enable", 0, o_par_oe);
      send(1'b0, 1'b0, 8'h82, 24'h123456, 1'b0);
      i_por_n = 1'b1;
      cyc(SUPPLY_TO_SELECT_CYC);
      chk("standby", 1, o_standby);
      chk("write gate", 1, o_write_allowed);
      $display("test power done");
   endtask

   task automatic t_cmds();
      logic [7:0] ops[20] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88,
         8'h89, 8'h9f, 8'hb9, 8'hab, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd7, 8'he8, 8'h00};
      for (int m = 0; m < 2; m++)
         foreach (ops[k])
            send(m[0], k[0], ops[k], {ops[k], ~ops[k], ops[k] ^ 8'hc3}, ops[k] != 8'h00);
      send(1'b1, 1'b1, 8'h82, 24'hffffff, 1'b1);
      $display("test commands done");
   endtask

   // Polls ready instead of waiting a fixed time, as the engine time varies.
   task automatic t_busy();
      logic ok;
      ok = 1'b0;
      i_busy = 1'b1;
      cyc(3);
      chk("ready while busy", 0, o_ready);
      i_busy = 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         cyc(1);
         ok = (o_ready === 1'b1);
      end
      chk("ready polled", 1, ok);
      cyc(10);
      chk("standby after busy", 1, o_standby);
      $display("test busy done");
   endtask

   task automatic t_reset();
      send(1'b0, 1'b0, 8'h9f, 24'h000000, 1'b1);
      i_rst_n = 1'b0;
      cyc(3);
      i_rst_n = 1'b1;
      cyc(2);
      chk("mode after second reset", 1, o_mode3);
      send(1'b0, 1'b1, 8'hd2, 24'habcdef, 1'b1);
      $display("test reset done");
   endtask

   initial begin
      t_power();
      t_cmds();
      t_busy();
      t_reset();
      conclude();
   end

   // Whole run is about three thousand cycles; this leaves ample margin.
   initial begin
      #3000000;
      n_fail++;
      $display("BAD watchdog expected finish seen timeout");
      conclude();
   end
endmodule
